// ---- dmame_pkg.sv ----
package dmame_pkg;
  localparam int NUM_CH        = 2;
  localparam int CNT_W         = 16;
  // control bit positions within the 9-bit control readback view
  localparam int BIT_ME1       = 7;
  localparam int BIT_RSV8      = 8;
  localparam int BIT_TE1       = 6;
  localparam int BIT_ME0       = 5;
  localparam int BIT_TE0       = 4;
  localparam int CTRL_W        = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  typedef enum logic {DMAME_BURST, DMAME_BLOCK} dmame_mode_t;

  typedef enum logic [1:0] {DMAME_IDLE, DMAME_XFER, DMAME_HALT} dmame_state_t;

  // software access to one channel's enable bits
  typedef struct packed {
    logic rd;
    logic wr;
    logic me;
    logic te;
  } dmame_sw_t;
endpackage

// ---- dmame_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RQ1: transfer only when both enables set
// RQ2: burst NMI clears master, halts, frees bus
// RQ3: setting master again resumes halted burst
// RQ4: block mode ignores NMI entirely
// RQ5: initialization clears all master enables
// RQ6: writing zero clears master enable
// RQ7: set needs prior read as zero
// RQ8: channel 1 master enable at bit 7
// RQ9: reserved bit 8 read/write, resets zero
// RQ10: enabled channel transfers on activation request
// RQ11: transfer enable clears when count exhausted
module dmame_top #(
  parameter int NCH = dmame_pkg::NUM_CH,
  parameter int CW  = dmame_pkg::CNT_W
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_nmi,
  input  wire dmame_pkg::dmame_sw_t [NCH-1:0] i_sw,
  input  wire logic                      i_rsv_wr,
  input  wire logic                      i_rsv_wdata,
  input  wire logic [NCH-1:0]            i_mode_block,
  input  wire logic [NCH-1:0]            i_req,
  input  wire logic [NCH-1:0]            i_cnt_load,
  input  wire logic [CW-1:0]             i_cnt_value,
  output logic [NCH-1:0]                 o_master_enable,
  output logic [NCH-1:0]                 o_transfer_enable,
  output logic [NCH-1:0]                 o_xfer,
  output logic                           o_bus_req,
  output logic [NCH-1:0]                 o_halted,
  output logic [dmame_pkg::CTRL_W-1:0]   o_ctrl_rd
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // per-channel enable and sequencing
  // ****************************************
  logic [NCH-1:0]      me;
  logic [NCH-1:0]      te;
  logic [NCH-1:0]      armed;
  logic [NCH-1:0]      xfer;
  logic [NCH-1:0]      halted;
  logic [NCH-1:0]      next_me;
  logic [NCH-1:0]      next_te;
  logic [NCH-1:0]      next_armed;
  logic [NCH-1:0]      next_xfer;
  logic [NCH-1:0]      next_halted;
  logic [CW-1:0]       cnt        [NCH];
  logic [CW-1:0]       next_cnt   [NCH];
  dmame_pkg::dmame_state_t st      [NCH];
  dmame_pkg::dmame_state_t next_st [NCH];
  logic rsv;
  logic next_rsv;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_comb begin
        next_me[g]     = me[g];
        next_te[g]     = te[g];
        next_armed[g]  = armed[g];
        next_xfer[g]   = 1'b0;
        next_halted[g] = halted[g];
        next_cnt[g]    = cnt[g];
        next_st[g]     = st[g];
        // RQ7 read-before-set latch
        if (i_sw[g].rd && !me[g]) begin
          next_armed[g] = 1'b1;
        end
        if (i_sw[g].wr) begin
          next_te[g] = i_sw[g].te;
          // RQ6 RQ7 write clears or sets
          if (!i_sw[g].me) begin
            next_me[g] = 1'b0;
          end else if (armed[g]) begin
            next_me[g] = 1'b1;
          end
          next_armed[g] = 1'b0;
        end
        if (i_cnt_load[g]) begin
          next_cnt[g] = i_cnt_value;
        end
        case (st[g])
          dmame_pkg::DMAME_IDLE: begin
            // RQ1 RQ10 both enables gate requests
            if (me[g] && te[g] && i_req[g] && cnt[g] != '0) begin
              next_st[g] = dmame_pkg::DMAME_XFER;
            end
          end
          dmame_pkg::DMAME_XFER: begin
            // RQ2 RQ4 nmi halts burst only
            if (i_nmi && !i_mode_block[g]) begin
              next_me[g]     = 1'b0;
              next_halted[g] = 1'b1;
              next_st[g]     = dmame_pkg::DMAME_HALT;
            end else if (!(me[g] && te[g])) begin
              next_st[g] = dmame_pkg::DMAME_IDLE;
            end else begin
              next_xfer[g] = 1'b1;
              next_cnt[g]  = cnt[g] - CW'(1);
              // RQ11 count end clears transfer enable
              if (cnt[g] == CW'(1)) begin
                next_te[g] = 1'b0;
                next_st[g] = dmame_pkg::DMAME_IDLE;
              end
            end
          end
          default: begin
            // RQ3 master set resumes halted burst
            if (me[g] && te[g]) begin
              next_halted[g] = 1'b0;
              next_st[g]     = dmame_pkg::DMAME_XFER;
            end else if (!te[g]) begin
              next_halted[g] = 1'b0;
              next_st[g]     = dmame_pkg::DMAME_IDLE;
            end
          end
        endcase
      end

      always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
          // RQ5 initialization clears master enable
          me[g]     <= 1'b0;
          te[g]     <= 1'b0;
          armed[g]  <= 1'b0;
          xfer[g]   <= 1'b0;
          halted[g] <= 1'b0;
          cnt[g]    <= '0;
          st[g]     <= dmame_pkg::DMAME_IDLE;
        end else begin
          me[g]     <= next_me[g];
          te[g]     <= next_te[g];
          armed[g]  <= next_armed[g];
          xfer[g]   <= next_xfer[g];
          halted[g] <= next_halted[g];
          cnt[g]    <= next_cnt[g];
          st[g]     <= next_st[g];
        end
      end

      // RQ2 burst nmi clears master
      chk_nmi_clears_me: assert property ( // RQ2
        @(posedge i_mclk) disable iff (!rst_n)
        (st[g] == dmame_pkg::DMAME_XFER && i_nmi && !i_mode_block[g])
        |=> (!me[g] && halted[g] && !xfer[g]))
        else $error("nmi in burst did not halt channel");
      // RQ4 block mode keeps master enable
      chk_block_nmi: assert property ( // RQ4
        @(posedge i_mclk) disable iff (!rst_n)
        (st[g] == dmame_pkg::DMAME_XFER && i_mode_block[g] && me[g]
         && !i_sw[g].wr) |=> me[g])
        else $error("block mode lost master enable");
      // RQ1 no transfer without enables
      chk_xfer_gate: assert property ( // RQ1
        @(posedge i_mclk) disable iff (!rst_n)
        xfer[g] |-> $past(me[g]) && $past(te[g]))
        else $error("transfer without both enables");
      // RQ7 set only after read zero
      chk_set_armed: assert property ( // RQ7
        @(posedge i_mclk) disable iff (!rst_n)
        $rose(me[g]) |-> $past(armed[g]) && $past(i_sw[g].wr))
        else $error("master enable set without prior read");
      // RQ6 write zero clears
      chk_wr_zero: assert property ( // RQ6
        @(posedge i_mclk) disable iff (!rst_n)
        (i_sw[g].wr && !i_sw[g].me) |=> !me[g])
        else $error("write zero did not clear master");
      // RQ3 resume after re-enable
      chk_resume: assert property ( // RQ3
        @(posedge i_mclk) disable iff (!rst_n)
        (st[g] == dmame_pkg::DMAME_HALT && me[g] && te[g])
        |=> st[g] == dmame_pkg::DMAME_XFER)
        else $error("halted burst did not resume");
      // RQ11 last transfer clears te
      chk_count_end: assert property ( // RQ11
        @(posedge i_mclk) disable iff (!rst_n)
        (next_xfer[g] && cnt[g] == CW'(1)) |=> !te[g] ##1 !xfer[g])
        else $error("transfer enable kept after last transfer");
      // RQ10 request starts transfer
      // a burst nmi or a write in the start cycle may legally stop it
      chk_req_start: assert property ( // RQ10
        @(posedge i_mclk) disable iff (!rst_n)
        (st[g] == dmame_pkg::DMAME_IDLE && me[g] && te[g] && i_req[g]
         && cnt[g] != '0 && !i_sw[g].wr && !i_nmi)
        ##1 (!i_sw[g].wr && !(i_nmi && !i_mode_block[g]))
        |=> xfer[g])
        else $error("request did not start transfer");
    end
  endgenerate

  // ****************************************
  // reserved bit and outputs
  // ****************************************
  always_comb begin
    next_rsv = rsv;
    // RQ9 reserved bit stored as written
    if (i_rsv_wr) begin
      next_rsv = i_rsv_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsv <= 1'b0;
    end else begin
      rsv <= next_rsv;
    end
  end

  logic [dmame_pkg::CTRL_W-1:0] next_ctrl;
  always_comb begin
    next_ctrl = dmame_pkg::CTRL_RST;
    // RQ8 channel 1 master at bit 7
    next_ctrl[dmame_pkg::BIT_ME1]  = next_me[1];
    next_ctrl[dmame_pkg::BIT_TE1]  = next_te[1];
    next_ctrl[dmame_pkg::BIT_ME0]  = next_me[0];
    next_ctrl[dmame_pkg::BIT_TE0]  = next_te[0];
    next_ctrl[dmame_pkg::BIT_RSV8] = next_rsv;
  end

  // outputs registered; the readback mirrors state the cycle it updates
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_master_enable   <= '0;
      o_transfer_enable <= '0;
      o_xfer            <= '0;
      o_bus_req         <= 1'b0;
      o_halted          <= '0;
      o_ctrl_rd         <= dmame_pkg::CTRL_RST;
    end else begin
      o_master_enable   <= next_me;
      o_transfer_enable <= next_te;
      o_xfer            <= next_xfer;
      // RQ2 bus returns to cpu when no channel moves
      o_bus_req         <= |next_xfer;
      o_halted          <= next_halted;
      o_ctrl_rd         <= next_ctrl;
    end
  end
endmodule
`default_nettype wire

// ---- dmame_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmame_cpu_model (
  input  wire logic i_mclk,
  input  wire logic i_bus_req,
  input  wire logic i_nmi_cmd,
  output logic      o_nmi,
  output logic      o_cpu_owns_bus
);
  // nmi from cpu side
  // registered so the pulse is launched on an edge, never mid-cycle
  always @(posedge i_mclk) o_nmi <= i_nmi_cmd;
  assign o_cpu_owns_bus = !i_bus_req;
endmodule
`default_nettype wire

// ---- dmame_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmame_top_tb;
  logic i_mclk = 1'b0;
  logic i_rst_n, i_nmi, nmi_cmd, cpu_bus, i_rsv_wr, i_rsv_wdata, o_bus_req;
  dmame_pkg::dmame_sw_t [1:0] i_sw;
  logic [1:0] i_mode_block, i_req, i_cnt_load;
  logic [1:0] o_master_enable, o_transfer_enable, o_xfer, o_halted;
  logic [15:0] i_cnt_value;
  logic [8:0] o_ctrl_rd;
  logic [8:0] n0 = 9'h000;
  logic [8:0] n1 = 9'h000;
  int err_total = 0;
  int samples_checked = 0;
  always #10 i_mclk = ~i_mclk;
  dmame_top dmame_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_nmi(i_nmi), .i_sw(i_sw), .i_rsv_wr(i_rsv_wr),
    .i_rsv_wdata(i_rsv_wdata), .i_mode_block(i_mode_block),
    .i_req(i_req), .i_cnt_load(i_cnt_load), .i_cnt_value(i_cnt_value),
    .o_master_enable(o_master_enable), .o_transfer_enable(o_transfer_enable),
    .o_xfer(o_xfer), .o_bus_req(o_bus_req), .o_halted(o_halted),
    .o_ctrl_rd(o_ctrl_rd));
  dmame_cpu_model dmame_cpu_model_inst (.i_mclk(i_mclk),
    .i_bus_req(o_bus_req), .i_nmi_cmd(nmi_cmd), .o_nmi(i_nmi),
    .o_cpu_owns_bus(cpu_bus));
  // units seen per channel; sampled before the edge's own updates
  always @(posedge i_mclk) begin
    if (o_xfer[0] === 1'b1) n0 <= n0 + 9'h001;
    if (o_xfer[1] === 1'b1) n1 <= n1 + 9'h001;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task chk(input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task step;
    @(posedge i_mclk);
    #2;
  endtask
  // v is {rd, wr, me, te}, held for one edge
  task sw(input int c, input logic [3:0] v);
    i_sw[c] = v;
    step;
    i_sw[c] = 4'h0;
  endtask
  task rsv(input logic v);
    i_rsv_wr = 1'b1;
    i_rsv_wdata = v;
    step;
    i_rsv_wr = 1'b0;
    step;
  endtask
  // x=1: wait for a unit, x=0: wait for transfer enable to drop
  task wt(input int c, input bit x);
    for (int i = 0; i < 60; i++) begin
      @(negedge i_mclk);
      if (x ? o_xfer[c] === 1'b1 : o_transfer_enable[c] === 1'b0) break;
    end
    step;
  endtask
  task pulse_nmi;
    nmi_cmd = 1'b1;
    step;
    nmi_cmd = 1'b0;
    repeat (3) step;
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {i_rst_n, nmi_cmd, i_rsv_wr, i_rsv_wdata} = 4'h0;
    {i_sw, i_req, i_cnt_load} = '0;
    i_mode_block = 2'b01;
    i_cnt_value = 16'h0008;
    repeat (20) step;
    i_rst_n = 1'b1;
    repeat (3) step;
    chk(o_ctrl_rd, 9'h000);
    chk({o_master_enable, o_transfer_enable}, 9'h000);
    sw(1, 4'h6);
    step;
    chk(o_master_enable[1], 1'b0);
    sw(1, 4'h8);
    sw(1, 4'h7);
    step;
    chk(o_ctrl_rd[7:6], 2'h3);
    chk(o_master_enable[1], 1'b1);
    rsv(1'b1);
    chk(o_ctrl_rd[8], 1'b1);
    rsv(1'b0);
    chk(o_ctrl_rd[8], 1'b0);
    i_cnt_load = 2'b01;
    step;
    i_cnt_load = 2'b00;
    sw(0, 4'h5);
    i_req[0] = 1'b1;
    repeat (6) step;
    chk(n0, 9'h000);
    sw(0, 4'h8);
    sw(0, 4'h7);
    wt(0, 1);
    pulse_nmi;
    chk(o_master_enable[0], 1'b1);
    chk(o_halted[0], 1'b0);
    wt(0, 0);
    chk(n0, 9'h008);
    i_req[0] = 1'b0;
    i_cnt_value = 16'h000a;
    i_cnt_load = 2'b10;
    step;
    i_cnt_load = 2'b00;
    i_req[1] = 1'b1;
    wt(1, 1);
    chk(o_bus_req, 1'b1);
    pulse_nmi;
    chk(o_master_enable[1], 1'b0);
    chk({o_halted[1], o_xfer[1], cpu_bus}, 3'h5);
    sw(1, 4'h8);
    sw(1, 4'h7);
    wt(1, 1);
    wt(1, 0);
    chk(n1, 9'h00a);
    chk(o_transfer_enable[1], 1'b0);
    sw(1, 4'h4);
    step;
    chk(o_master_enable[1], 1'b0);
    conclude;
  end
  // whole run is under a hundred cycles
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
